// ### mbag_circ.sv
// Circular buffer boundary check and wrap for one address generator.
// Assumes start and end are byte addresses of the first and last word.
`timescale 1ns/1ps

module mbag_circ
    import mbag_pkg::*;
(
    // Address to check.
    input  logic [15:0] addr_in,
    input  logic        inc,
    input  logic        en,
    // Buffer boundaries.
    input  logic [15:0] start_addr,
    input  logic [15:0] end_addr,
    // Result.
    output logic [15:0] addr_out,
    output logic        wrapped
);

    logic [16:0] len;
    logic        pow2;
    logic        over_hi;
    logic        under_lo;

    // Length is end minus start plus one word, so no length register exists.
    // Bit 0 of both boundaries is ignored: the end register reads back odd, yet it names the last word.
    assign len  = {1'b0, end_addr[15:1], 1'b0} - {1'b0, start_addr[15:1], 1'b0} + 17'h00002;
    assign pow2 = ((len & (len - 17'h00001)) == 17'h00000);

    // Compare beyond the boundary, so an overshooting step still wraps.
    assign over_hi  = (addr_in > end_addr) && (inc || pow2);
    assign under_lo = (addr_in < start_addr) && (!inc || pow2);

    // Wrap by one buffer length back inside the buffer.
    always_comb begin
        addr_out = addr_in;
        wrapped  = 1'b0;
        if (en && over_hi) begin
            addr_out = addr_in - len[15:0];
            wrapped  = 1'b1;
        end else if (en && under_lo) begin
            addr_out = addr_in + len[15:0];
            wrapped  = 1'b1;
        end
    end

endmodule // mbag_circ

// ### mbag_core_model.sv
// Pointer file of the core pipeline that feeds the three generators.
// Assumes write-back arrives one cycle after each request, as the block answers.
`timescale 1ns/1ps

module mbag_core_model (
    // Clock and reset.
    input  logic        clk,
    input  logic        rst,
    // Pointer preload from the bench.
    input  logic [2:0]  ld,
    input  logic [15:0] ld_val,
    // Write-back from the generators.
    input  logic [2:0]  wb_en,
    input  logic [15:0] xr_wb,
    input  logic [15:0] xw_wb,
    input  logic [15:0] y_wb,
    // Pointers shown with each request.
    output logic [15:0] xr_ptr,
    output logic [15:0] xw_ptr,
    output logic [15:0] y_ptr
);
    // Like the real core, a pointer changes only by preload or write-back.
    always_ff @(posedge clk) begin
        if (rst) begin
            xr_ptr <= 16'h0000;
            xw_ptr <= 16'h0000;
            y_ptr  <= 16'h0000;
        end else begin
            xr_ptr <= ld[0] ? ld_val : (wb_en[0] ? xr_wb : xr_ptr);
            xw_ptr <= ld[1] ? ld_val : (wb_en[1] ? xw_wb : xw_ptr);
            y_ptr  <= ld[2] ? ld_val : (wb_en[2] ? y_wb : y_ptr);
        end
    end
endmodule // mbag_core_model

// ### mbag_defines.svh
// Register offsets, field positions and reset values of the modulo and
// bit-reversed address correction block. Assumes a 32-bit APB register bus.
`ifndef MBAG_DEFINES_SVH
`define MBAG_DEFINES_SVH

// Byte offsets of the registers on the APB bus.
`define MBAG_OFS_CTRL    8'h00
`define MBAG_OFS_PIVOT   8'h04
`define MBAG_OFS_XSTART  8'h08
`define MBAG_OFS_XEND    8'h0C
`define MBAG_OFS_YSTART  8'h10
`define MBAG_OFS_YEND    8'h14
`define MBAG_OFS_STATUS  8'h18

// Fields of the circular and reverse control register.
`define MBAG_F_XSEL      3:0
`define MBAG_F_YSEL      7:4
`define MBAG_F_RSEL      11:8
`define MBAG_B_YEN       14
`define MBAG_B_XEN       15

// Fields of the reverse pivot control register.
`define MBAG_F_PIVOT     14:0
`define MBAG_B_RENABLE   15

// Pointer-select code that means no pointer.
`define MBAG_SEL_NONE    4'hF

// Reset values.
`define MBAG_RST_CTRL    16'h0FFF
`define MBAG_RST_PIVOT   16'h0000
`define MBAG_RST_START   16'h0000
`define MBAG_RST_END     16'h0001

// Status bits: wrap at the last request per generator, bit reversal at the last X write.
`define MBAG_S_XRWRAP    0
`define MBAG_S_XWWRAP    1
`define MBAG_S_YWRAP     2
`define MBAG_S_REV       3

`endif

// ### mbag_monitor.sv
// Checker of the address correction block, bound to its top module.
// Assumes it sees only top-level ports; internal pointers are not visible.
`timescale 1ns/1ps

module mbag_monitor
    import mbag_pkg::*;
#(
    parameter int APB_AW = 8
) (
    // Clock, reset and APB.
    input logic              clk,
    input logic              rst,
    input logic              psel,
    input logic              penable,
    input logic [APB_AW-1:0] paddr,
    input logic              pready,
    input logic              pslverr,
    // Generator ports.
    input logic              xr_valid,
    input logic [15:0]       xr_ptr,
    input mbag_am_t          xr_mode,
    input logic              xr_done,
    input logic [15:0]       xr_ea,
    input logic              xr_wb_en,
    input logic              xw_valid,
    input logic              xw_done,
    input logic              y_done,
    input logic [15:0]       y_ea,
    input logic [15:0]       y_wb
);
    // Everything runs on the single core clock, so one default is enough.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_apb_nowait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_apb_unmapped: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("no error on unmapped address");
    a_xr_latency: assert property (xr_valid |=> xr_done)
        else $error("x read result late");
    a_xr_spurious: assert property (!xr_valid |=> !xr_done)
        else $error("x read result without request");
    a_ofs_nowrite: assert property (xr_valid && xr_mode == MBAG_AM_OFS |=> !xr_wb_en)
        else $error("offset mode wrote pointer back");
    a_post_ea: assert property (xr_valid && xr_mode == MBAG_AM_POST |=> xr_wb_en && xr_ea == $past(xr_ptr))
        else $error("post modify address or write-back wrong");
    a_ind_linear: assert property (xr_valid && xr_mode == MBAG_AM_IND |=> xr_ea == $past(xr_ptr) && !xr_wb_en)
        else $error("plain indirect address altered");
    a_y_word: assert property (y_done |-> !y_ea[0] && !y_wb[0])
        else $error("y address bit 0 set");
    a_xw_pulse: assert property (xw_valid ##1 !xw_valid |-> xw_done ##1 !xw_done)
        else $error("x write result not a single pulse");
endmodule // mbag_monitor

bind mbag_top mbag_monitor #(.APB_AW(APB_AW)) mon_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .xr_valid(xr_valid), .xr_ptr(xr_ptr), .xr_mode(xr_mode), .xr_done(xr_done),
    .xr_ea(xr_ea), .xr_wb_en(xr_wb_en), .xw_valid(xw_valid), .xw_done(xw_done), .y_done(y_done),
    .y_ea(y_ea), .y_wb(y_wb)
);

// ### mbag_pkg.sv
// Types of the modulo and bit-reversed address correction block.
// Assumes mbag_defines.svh for all numeric constants.
package mbag_pkg;

    // Addressing mode of one effective-address request.
    typedef enum logic [1:0] {
        MBAG_AM_IND  = 2'b00,
        MBAG_AM_POST = 2'b01,
        MBAG_AM_PRE  = 2'b10,
        MBAG_AM_OFS  = 2'b11
    } mbag_am_t;

    // Registered result of one address generator.
    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic [15:0] wb;
        logic        wb_en;
    } mbag_res_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] pivot;
        logic [15:0] xs;
        logic [15:0] xe;
        logic [15:0] ys;
        logic [15:0] ye;
        logic [3:0]  stat;
        logic [31:0] rdata;
        mbag_res_t   xr;
        mbag_res_t   xw;
        mbag_res_t   y;
    } mbag_st_t;

endpackage

// ### mbag_top.sv
// Modulo effective-address correction for the X read, X write and Y address generators,
// with bit-reversed correction for X write only, and its control registers on APB.
// Assumes the core pipeline presents one request per generator per cycle on clk
// and takes the corrected address one cycle later.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "mbag_defines.svh"

module mbag_top
    import mbag_pkg::*;
#(
    parameter int APB_AW = 8
) (
    // Clock and reset.
    input  logic        clk,
    input  logic        rst,
    // APB slave.
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [APB_AW-1:0] paddr,
    input  logic [31:0] pwdata,
    input  logic [3:0]  pstrb,
    output logic        pready,
    output logic [31:0] prdata,
    output logic        pslverr,
    // X read generator request.
    input  logic        xr_valid,
    input  logic [3:0]  xr_reg,
    input  logic [15:0] xr_ptr,
    input  logic [15:0] xr_delta,
    input  mbag_am_t    xr_mode,
    // X read generator result.
    output logic        xr_done,
    output logic [15:0] xr_ea,
    output logic [15:0] xr_wb,
    output logic        xr_wb_en,
    // X write generator request.
    input  logic        xw_valid,
    input  logic [3:0]  xw_reg,
    input  logic [15:0] xw_ptr,
    input  logic [15:0] xw_delta,
    input  mbag_am_t    xw_mode,
    input  logic        xw_word,
    // X write generator result.
    output logic        xw_done,
    output logic [15:0] xw_ea,
    output logic [15:0] xw_wb,
    output logic        xw_wb_en,
    // Y generator request.
    input  logic        y_valid,
    input  logic [3:0]  y_reg,
    input  logic [15:0] y_ptr,
    input  logic [15:0] y_delta,
    input  mbag_am_t    y_mode,
    // Y generator result.
    output logic        y_done,
    output logic [15:0] y_ea,
    output logic [15:0] y_wb,
    output logic        y_wb_en
);

    // The decoder compares eight address bits.
    if (APB_AW < 8) begin : g_chk
        $error("mbag_top: APB_AW must be at least 8");
    end

    mbag_st_t    s_q;
    mbag_st_t    s_d;

    logic [15:0] xr_lin;
    logic [15:0] xw_lin;
    logic [15:0] y_lin;
    logic [15:0] xr_cor;
    logic [15:0] xw_cor;
    logic [15:0] y_cor;
    logic        xr_wrap;
    logic        xw_wrap;
    logic        y_wrap;
    logic        xr_men;
    logic        xw_men;
    logic        y_men;
    logic        rev_on;
    logic [15:0] rev_next;
    logic        acc;
    logic        setup;
    logic        hit;
    logic [31:0] rd_mux;
    logic        hi_ok;

    // Mirror a 16-bit word end for end.
    function automatic logic [15:0] flip16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // Merge write data into a 16-bit register under byte strobes.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Linear next pointer of each generator.
    assign xr_lin = xr_ptr + xr_delta;
    assign xw_lin = xw_ptr + xw_delta;
    assign y_lin  = y_ptr + y_delta;

    assign rev_on = (s_q.ctrl[`MBAG_F_RSEL] != `MBAG_SEL_NONE) && s_q.pivot[`MBAG_B_RENABLE]
                    && (xw_reg == s_q.ctrl[`MBAG_F_RSEL]) && xw_word
                    && ((xw_mode == MBAG_AM_PRE) || (xw_mode == MBAG_AM_POST))
                    && !xw_delta[15] && (xw_delta != 16'h0000);

    // visiting order follows.
    // Mirroring both operands turns a normal adder into one carrying downward.
    assign rev_next = flip16(flip16(xw_ptr) + flip16({s_q.pivot[`MBAG_F_PIVOT], 1'b0})) & 16'hFFFE;

    // one X and one Y buffer.
    assign xr_men = s_q.ctrl[`MBAG_B_XEN] && (s_q.ctrl[`MBAG_F_XSEL] != `MBAG_SEL_NONE)
                    && (xr_reg == s_q.ctrl[`MBAG_F_XSEL]) && (xr_mode != MBAG_AM_IND);
    assign xw_men = s_q.ctrl[`MBAG_B_XEN] && (s_q.ctrl[`MBAG_F_XSEL] != `MBAG_SEL_NONE)
                    && (xw_reg == s_q.ctrl[`MBAG_F_XSEL]) && (xw_mode != MBAG_AM_IND) && !rev_on;
    assign y_men  = s_q.ctrl[`MBAG_B_YEN] && (s_q.ctrl[`MBAG_F_YSEL] != `MBAG_SEL_NONE)
                    && (y_reg == s_q.ctrl[`MBAG_F_YSEL]) && (y_mode != MBAG_AM_IND);

    mbag_circ u_circ_xr (
        .addr_in    (xr_lin),
        .inc        (!xr_delta[15]),
        .en         (xr_men),
        .start_addr (s_q.xs),
        .end_addr   (s_q.xe),
        .addr_out   (xr_cor),
        .wrapped    (xr_wrap)
    );

    mbag_circ u_circ_xw (
        .addr_in    (xw_lin),
        .inc        (!xw_delta[15]),
        .en         (xw_men),
        .start_addr (s_q.xs),
        .end_addr   (s_q.xe),
        .addr_out   (xw_cor),
        .wrapped    (xw_wrap)
    );

    mbag_circ u_circ_y (
        .addr_in    (y_lin),
        .inc        (!y_delta[15]),
        .en         (y_men),
        .start_addr (s_q.ys),
        .end_addr   (s_q.ye),
        .addr_out   (y_cor),
        .wrapped    (y_wrap)
    );

    // APB phases; the slave answers in the first access cycle.
    assign setup   = psel && !penable;
    assign acc     = psel && penable;
    assign pready  = acc;
    assign prdata  = s_q.rdata;
    assign pslverr = acc && !hit;

    // Upper address bits exist only when the bus is wider than the decoder.
    if (APB_AW > 8) begin : g_hi
        assign hi_ok = (paddr[APB_AW-1:8] == '0);
    end else begin : g_nohi
        assign hi_ok = 1'b1;
    end

    // Address decode and read data, taken in the setup cycle into a register.
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h00000000;
        unique case (paddr[7:0])
            `MBAG_OFS_CTRL:   rd_mux = {16'h0000, s_q.ctrl};
            `MBAG_OFS_PIVOT:  rd_mux = {16'h0000, s_q.pivot};
            `MBAG_OFS_XSTART: rd_mux = {16'h0000, s_q.xs};
            `MBAG_OFS_XEND:   rd_mux = {16'h0000, s_q.xe};
            `MBAG_OFS_YSTART: rd_mux = {16'h0000, s_q.ys};
            `MBAG_OFS_YEND:   rd_mux = {16'h0000, s_q.ye};
            `MBAG_OFS_STATUS: rd_mux = {28'h0000000, s_q.stat};
            default:          hit    = 1'b0;
        endcase
        if (!hi_ok) begin
            hit    = 1'b0;
            rd_mux = 32'h00000000;
        end
    end

    // Next state: registers, bus read data and the three generator results.
    always_comb begin
        s_d = s_q;
        if (setup && !pwrite) begin
            s_d.rdata = rd_mux;
        end
        // Writes land at the access edge; the status register is read-only.
        if (acc && pwrite && hit) begin
            unique case (paddr[7:0])
                `MBAG_OFS_CTRL:   s_d.ctrl  = merge16(s_q.ctrl, pwdata, pstrb);
                `MBAG_OFS_PIVOT:  s_d.pivot = merge16(s_q.pivot, pwdata, pstrb);
                // length from start and end only.
                `MBAG_OFS_XSTART: s_d.xs    = merge16(s_q.xs, pwdata, pstrb) & 16'hFFFE;
                `MBAG_OFS_XEND:   s_d.xe    = merge16(s_q.xe, pwdata, pstrb) | 16'h0001;
                `MBAG_OFS_YSTART: s_d.ys    = merge16(s_q.ys, pwdata, pstrb) & 16'hFFFE;
                `MBAG_OFS_YEND:   s_d.ye    = merge16(s_q.ye, pwdata, pstrb) | 16'h0001;
                default:          s_d.stat  = s_q.stat;
            endcase
        end

        // X read result; the write-back value is the corrected pointer.
        s_d.xr.valid = xr_valid;
        if (xr_valid) begin
            s_d.xr.ea    = (xr_mode == MBAG_AM_IND || xr_mode == MBAG_AM_POST) ? xr_ptr : xr_cor;
            s_d.xr.wb    = xr_cor;
            s_d.xr.wb_en = (xr_mode == MBAG_AM_PRE) || (xr_mode == MBAG_AM_POST);
            s_d.stat[`MBAG_S_XRWRAP] = xr_wrap;
        end

        // X write result; bit reversal replaces the mode's own increment.
        s_d.xw.valid = xw_valid;
        if (xw_valid) begin
            s_d.xw.wb_en = (xw_mode == MBAG_AM_PRE) || (xw_mode == MBAG_AM_POST);
            if (rev_on) begin
                s_d.xw.ea = (xw_mode == MBAG_AM_POST) ? (xw_ptr & 16'hFFFE) : rev_next;
                s_d.xw.wb = rev_next;
            end else begin
                s_d.xw.ea = (xw_mode == MBAG_AM_IND || xw_mode == MBAG_AM_POST) ? xw_ptr : xw_cor;
                s_d.xw.wb = xw_cor;
            end
            s_d.stat[`MBAG_S_XWWRAP] = xw_wrap;
            s_d.stat[`MBAG_S_REV]    = rev_on;
        end

        // Y result; all Y accesses are words.
        s_d.y.valid = y_valid;
        if (y_valid) begin
            s_d.y.ea    = ((y_mode == MBAG_AM_IND || y_mode == MBAG_AM_POST) ? y_ptr : y_cor) & 16'hFFFE;
            s_d.y.wb    = y_cor & 16'hFFFE;
            s_d.y.wb_en = (y_mode == MBAG_AM_PRE) || (y_mode == MBAG_AM_POST);
            s_d.stat[`MBAG_S_YWRAP] = y_wrap;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q       <= '0;
            s_q.ctrl  <= `MBAG_RST_CTRL;
            s_q.pivot <= `MBAG_RST_PIVOT;
            s_q.xs    <= `MBAG_RST_START;
            s_q.xe    <= `MBAG_RST_END;
            s_q.ys    <= `MBAG_RST_START;
            s_q.ye    <= `MBAG_RST_END;
        end else begin
            s_q <= s_d;
        end
    end

    // Results come straight from the state register.
    assign xr_done  = s_q.xr.valid;
    assign xr_ea    = s_q.xr.ea;
    assign xr_wb    = s_q.xr.wb;
    assign xr_wb_en = s_q.xr.valid && s_q.xr.wb_en;
    assign xw_done  = s_q.xw.valid;
    assign xw_ea    = s_q.xw.ea;
    assign xw_wb    = s_q.xw.wb;
    assign xw_wb_en = s_q.xw.valid && s_q.xw.wb_en;
    assign y_done   = s_q.y.valid;
    assign y_ea     = s_q.y.ea;
    assign y_wb     = s_q.y.wb;
    assign y_wb_en  = s_q.y.valid && s_q.y.wb_en;

endmodule // mbag_top

// ### mbag_top_test.sv
// Self-checking bench of the address correction block with a pointer model.
// Assumes a 200 MHz clock and zero-wait APB as the block's note states.
`timescale 1ns/1ps
`include "mbag_defines.svh"

module mbag_top_test import mbag_pkg::*;;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, xw_word, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, g_reg;
    logic [2:0]  vld, ld, done, we;
    logic [15:0] g_dl, ld_val, xr_ptr, xw_ptr, y_ptr, xr_ea, xw_ea, y_ea, xr_wb, xw_wb, y_wb;
    mbag_am_t    g_md;
    int          n_mismatch, n_checks;

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    mbag_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .xr_valid(vld[0]), .xr_reg(g_reg), .xr_ptr(xr_ptr), .xr_delta(g_dl), .xr_mode(g_md),
        .xr_done(done[0]), .xr_ea(xr_ea), .xr_wb(xr_wb), .xr_wb_en(we[0]),
        .xw_valid(vld[1]), .xw_reg(g_reg), .xw_ptr(xw_ptr), .xw_delta(g_dl), .xw_mode(g_md), .xw_word(xw_word),
        .xw_done(done[1]), .xw_ea(xw_ea), .xw_wb(xw_wb), .xw_wb_en(we[1]),
        .y_valid(vld[2]), .y_reg(g_reg), .y_ptr(y_ptr), .y_delta(g_dl), .y_mode(g_md),
        .y_done(done[2]), .y_ea(y_ea), .y_wb(y_wb), .y_wb_en(we[2]));

    mbag_core_model core_u (.clk(clk), .rst(rst), .ld(ld), .ld_val(ld_val), .wb_en(we), .xr_wb(xr_wb),
        .xw_wb(xw_wb), .y_wb(y_wb), .xr_ptr(xr_ptr), .xw_ptr(xw_ptr), .y_ptr(y_ptr));

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Byte offset of entry i of a sixteen-word buffer in bit-reversed order.
    function automatic logic [15:0] rev_ofs(input int i);
        logic [3:0] v;
        v = 4'(i);
        return {11'h000, v[0], v[1], v[2], v[3], 1'b0};
    endfunction

    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // One generator request; a pointer of FFFF keeps the model's current value.
    task automatic gck(input int ch, input logic [15:0] p, input logic [3:0] r, input logic [15:0] dl,
                       input mbag_am_t md, input logic wd, input logic [15:0] eea, ewb, input logic ewe);
        if (p !== 16'hFFFF) begin
            @(posedge clk);
            ld <= 3'(1 << ch);
            ld_val <= p;
        end
        @(posedge clk);
        ld <= 3'h0;
        vld <= 3'(1 << ch);
        g_reg <= r;
        g_dl <= dl;
        g_md <= md;
        xw_word <= wd;
        @(posedge clk);
        vld <= 3'h0;
        #1;
        chk(done, 32'(1 << ch));
        chk(we[ch], ewe);
        chk(ch == 0 ? xr_ea : ch == 1 ? xw_ea : y_ea, eea);
        if (ewe) chk(ch == 0 ? xr_wb : ch == 1 ? xw_wb : y_wb, ewb);
        @(posedge clk);
    endtask

    task automatic t_regs();
        logic [31:0] rv [7] = '{32'h0FFF, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
        for (int i = 0; i < 7; i++) rg(8'(4 * i), rv[i]);
        apb(1'b1, `MBAG_OFS_STATUS, 32'hF);
        rg(`MBAG_OFS_STATUS, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask

    task automatic t_xmod();
        apb(1'b1, `MBAG_OFS_XSTART, 32'h1001);
        rg(`MBAG_OFS_XSTART, 32'h1000);
        apb(1'b1, `MBAG_OFS_XEND, 32'h100F);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h8FF3);
        // no stack pointer register is ever chosen as a circular pointer.
        gck(0, 16'h100E, 4'h3, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1000, 1'b1);
        gck(0, 16'h100C, 4'h3, 16'h0006, MBAG_AM_PRE, 1'b0, 16'h1002, 16'h1002, 1'b1);
        gck(0, 16'h100C, 4'h3, 16'h0006, MBAG_AM_OFS, 1'b0, 16'h1002, 16'h0, 1'b0);
        gck(0, 16'h1000, 4'h3, 16'hFFFE, MBAG_AM_POST, 1'b0, 16'h1000, 16'h100E, 1'b1);
        gck(0, 16'h100E, 4'h4, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1010, 1'b1);
        gck(1, 16'h100E, 4'h3, 16'h0002, MBAG_AM_POST, 1'b1, 16'h100E, 16'h1000, 1'b1);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h0FF3);
        gck(0, 16'h100E, 4'h3, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1010, 1'b1);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h8FFF);
        gck(1, 16'h100E, 4'hF, 16'h0002, MBAG_AM_POST, 1'b1, 16'h100E, 16'h1010, 1'b1);
        gck(0, 16'h100E, 4'hF, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1010, 1'b1);
    endtask

    task automatic t_ymod();
        apb(1'b1, `MBAG_OFS_YSTART, 32'h2000);
        apb(1'b1, `MBAG_OFS_YEND, 32'h2007);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h4F5F);
        gck(2, 16'h2006, 4'h5, 16'h0002, MBAG_AM_POST, 1'b0, 16'h2006, 16'h2000, 1'b1);
        gck(2, 16'h2003, 4'h5, 16'h0000, MBAG_AM_IND, 1'b0, 16'h2002, 16'h0, 1'b0);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h0F5F);
        gck(2, 16'h2006, 4'h5, 16'h0002, MBAG_AM_POST, 1'b0, 16'h2006, 16'h2008, 1'b1);
    endtask

    task automatic t_rev();
        apb(1'b1, `MBAG_OFS_CTRL, 32'h82F3);
        // pivot of eight words for a sixteen-word buffer, no read follows it
        apb(1'b1, `MBAG_OFS_PIVOT, 32'h8008);
        // buffer start aligned to its 32-byte size
        for (int i = 0; i < 16; i++)
            gck(1, i == 0 ? 16'h1000 : 16'hFFFF, 4'h2, 16'h0002, MBAG_AM_POST, 1'b1,
                16'h1000 + rev_ofs(i), 16'h1000 + rev_ofs(i + 1), 1'b1);
        gck(1, 16'h1000, 4'h2, 16'h0002, MBAG_AM_PRE, 1'b1, 16'h1010, 16'h1010, 1'b1);
        gck(0, 16'h100E, 4'h3, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1000, 1'b1);
        gck(1, 16'h1000, 4'h2, 16'h0001, MBAG_AM_POST, 1'b0, 16'h1000, 16'h1001, 1'b1);
        gck(1, 16'h1004, 4'h2, 16'h0002, MBAG_AM_IND, 1'b1, 16'h1004, 16'h0, 1'b0);
        gck(1, 16'h1004, 4'h2, 16'hFFFE, MBAG_AM_POST, 1'b1, 16'h1004, 16'h1002, 1'b1);
        gck(0, 16'h1004, 4'h2, 16'h0002, MBAG_AM_POST, 1'b0, 16'h1004, 16'h1006, 1'b1);
        // Same pointer for circular and reversed use: the write side reverses, the read side wraps.
        apb(1'b1, `MBAG_OFS_CTRL, 32'h8222);
        gck(1, 16'h100E, 4'h2, 16'h0002, MBAG_AM_POST, 1'b1, 16'h100E, 16'h101E, 1'b1);
        gck(0, 16'h100E, 4'h2, 16'h0002, MBAG_AM_POST, 1'b0, 16'h100E, 16'h1000, 1'b1);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h82F3);
        apb(1'b1, `MBAG_OFS_PIVOT, 32'h0008);
        gck(1, 16'h1004, 4'h2, 16'h0002, MBAG_AM_POST, 1'b1, 16'h1004, 16'h1006, 1'b1);
        // Enabled pivot but a reverse select of 15 must leave addresses linear.
        apb(1'b1, `MBAG_OFS_PIVOT, 32'h8008);
        apb(1'b1, `MBAG_OFS_CTRL, 32'h0FFF);
        gck(1, 16'h1004, 4'hF, 16'h0002, MBAG_AM_POST, 1'b1, 16'h1004, 16'h1006, 1'b1);
    endtask

    // Stops a hung handshake well after the expected run of a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    // Reset, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, xw_word, paddr, pwdata} = 44'h0;
        pstrb = 4'hF;
        {g_reg, vld, ld, g_dl, ld_val} = 42'h0;
        g_md = MBAG_AM_IND;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_xmod();
        t_ymod();
        t_rev();
        report_and_stop();
    end
endmodule // mbag_top_test
